// file: rtl/alarm_monitor_defines.svh
`ifndef ALARM_MONITOR_DEFINES_SVH
`define ALARM_MONITOR_DEFINES_SVH

// ****************************************************************
// Register port geometry
// ****************************************************************
`define AM_ADDR_W            8
`define AM_DATA_W            32

// ****************************************************************
// Register offsets
// ****************************************************************
`define AM_OFS_SUMMARY       8'h00
`define AM_OFS_STATUS        8'h04
`define AM_OFS_MASK          8'h08
`define AM_OFS_PIN_CFG       8'h0c
`define AM_OFS_DEV_CTRL      8'h10
`define AM_OFS_EVT_COUNT     8'h14
`define AM_OFS_MON_STATE     8'h18
`define AM_OFS_FIRST_ALARM   8'h1c

// ****************************************************************
// Alarm bit positions (status, mask and first-alarm share them)
// ****************************************************************
`define AM_NUM_ALARMS        2
`define AM_BIT_REALIGN       0
`define AM_BIT_CLK_UPSET     1

// ****************************************************************
// Device control bit positions
// ****************************************************************
`define AM_CTRL_OUT_EN       0
`define AM_CTRL_PD_A         1
`define AM_CTRL_PD_B         2
`define AM_CTRL_PD_GLOBAL    3

// ****************************************************************
// Status pin source select codes
// ****************************************************************
`define AM_PIN_SEL_W         2
`define AM_PIN_SEL_CAL       2'h0
`define AM_PIN_SEL_ALARM     2'h1

// ****************************************************************
// Reset values and event counter width
// ****************************************************************
`define AM_MASK_RST          2'h0
`define AM_PIN_SEL_RST       2'h0
`define AM_CTRL_RST          4'h0
`define AM_CNT_W             8

// ****************************************************************
// Clock comparison
// ****************************************************************
`define AM_CLK_W             4
`define AM_SETTLE_HALF       2'h1

`endif

// file: rtl/alarm_monitor_pkg.sv
`include "alarm_monitor_defines.svh"

package alarm_monitor_pkg;

  typedef enum logic [1:0] {
    CMP_OFF,
    CMP_SETTLE,
    CMP_RUN
  } cmp_state_type;

  typedef struct packed {
    cmp_state_type             state;
    logic                      phase;
    logic [1:0]                settleCnt;
    logic [`AM_CLK_W-1:0]      sampA;
    logic [`AM_CLK_W-1:0]      sampB;
    logic                      upset;
  } cmp_regs_type;

  typedef struct packed {
    logic [`AM_NUM_ALARMS-1:0] status;
    logic [`AM_NUM_ALARMS-1:0] mask;
    logic [`AM_NUM_ALARMS-1:0] first;
    logic [`AM_PIN_SEL_W-1:0]  pinSel;
    logic [3:0]                ctrl;
    logic                      pdPrev;
    logic [`AM_CNT_W-1:0]      cntRealign;
    logic [`AM_CNT_W-1:0]      cntUpset;
    logic [`AM_DATA_W-1:0]     rdData;
    logic                      irq;
    logic                      statusPin;
  } mon_regs_type;

endpackage

// file: rtl/clk_cmp_if.sv
`timescale 1ns/1ns
`include "alarm_monitor_defines.svh"

interface clk_cmp_if;
  logic                 enable;
  logic [`AM_CLK_W-1:0] chanAClk;
  logic [`AM_CLK_W-1:0] chanBClk;
  logic                 upsetPulse;
  alarm_monitor_pkg::cmp_state_type state;

  modport monitor (
    output enable,
    output chanAClk,
    output chanBClk,
    input  upsetPulse,
    input  state
  );

  modport comparator (
    input  enable,
    input  chanAClk,
    input  chanBClk,
    output upsetPulse,
    output state
  );
endinterface

// file: rtl/clock_compare.sv
`timescale 1ns/1ns
`include "alarm_monitor_defines.svh"

module clock_compare (
  input  wire logic  core_clk,  // Core clock
  input  wire logic  sys_rst,   // Synchronous reset, active high
  clk_cmp_if.comparator cmp     // Link to the alarm monitor
);

  alarm_monitor_pkg::cmp_regs_type regs_ff;
  alarm_monitor_pkg::cmp_regs_type nxt_regs;

  // ****************************************************************
  // Half-rate comparison of the two channel clock sets
  // ****************************************************************
  always_comb begin
    nxt_regs       = regs_ff;
    nxt_regs.upset = 1'b0;
    unique case (regs_ff.state)
      alarm_monitor_pkg::CMP_OFF: begin
        nxt_regs.phase     = 1'b0;
        nxt_regs.settleCnt = `AM_SETTLE_HALF;
        if (cmp.enable) begin
          nxt_regs.state = alarm_monitor_pkg::CMP_SETTLE;
        end
      end
      alarm_monitor_pkg::CMP_SETTLE: begin
        // Clocks realign when the output path comes back; skip that window
        nxt_regs.phase = ~regs_ff.phase;
        if (!cmp.enable) begin
          nxt_regs.state = alarm_monitor_pkg::CMP_OFF;
        end else if (regs_ff.phase) begin
          if (regs_ff.settleCnt == 2'h0) begin
            nxt_regs.state = alarm_monitor_pkg::CMP_RUN;
          end else begin
            nxt_regs.settleCnt = regs_ff.settleCnt - 2'h1;
          end
        end
      end
      alarm_monitor_pkg::CMP_RUN: begin
        nxt_regs.phase = ~regs_ff.phase;
        if (!cmp.enable) begin
          nxt_regs.state = alarm_monitor_pkg::CMP_OFF;
        end else if (!regs_ff.phase) begin
          nxt_regs.sampA = cmp.chanAClk;
          nxt_regs.sampB = cmp.chanBClk;
        end else begin
          // One differing half-rate sample is enough
          nxt_regs.upset = (regs_ff.sampA != regs_ff.sampB);
        end
      end
      default: begin
        nxt_regs.state = alarm_monitor_pkg::CMP_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regs_ff <= '{state: alarm_monitor_pkg::CMP_OFF, settleCnt: `AM_SETTLE_HALF,
                   default: '0};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign cmp.upsetPulse = regs_ff.upset;
  assign cmp.state      = regs_ff.state;

endmodule // clock_compare

// file: rtl/alarm_monitor.sv
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "alarm_monitor_defines.svh"

module alarm_monitor (
  input  wire logic                  core_clk,      // Core clock, 50 MHz
  input  wire logic                  sys_rst,       // Synchronous reset, active high
  input  wire logic [`AM_ADDR_W-1:0] regAddr,       // Register byte address
  input  wire logic [`AM_DATA_W-1:0] regWrData,     // Register write data
  input  wire logic                  regWrEn,       // Write strobe
  input  wire logic                  regRdEn,       // Read strobe
  output logic      [`AM_DATA_W-1:0] regRdData,     // Read data, cycle after strobe
  input  wire logic                  sysrefRealign, // Pulse: clocks realigned by reference
  input  wire logic [`AM_CLK_W-1:0]  chanAClocks,   // Channel A internal clock phases
  input  wire logic [`AM_CLK_W-1:0]  chanBClocks,   // Channel B internal clock phases
  input  wire logic                  powerdownPin,  // Global power-down pin, active high
  input  wire logic                  calDoneIn,     // Calibration status for the pin
  output logic                       statusOutPin,  // Status output pin
  output logic                       alarmIrq       // Summary alarm / interrupt level
);

  alarm_monitor_pkg::mon_regs_type regs_ff;
  alarm_monitor_pkg::mon_regs_type nxt_regs;

  clk_cmp_if cmpLink ();

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic wrStatus;
  logic wrMask;
  logic wrPinCfg;
  logic wrCtrl;
  logic wrEvtCount;

  assign wrStatus   = regWrEn && (regAddr == `AM_OFS_STATUS);
  assign wrMask     = regWrEn && (regAddr == `AM_OFS_MASK);
  assign wrPinCfg   = regWrEn && (regAddr == `AM_OFS_PIN_CFG);
  assign wrCtrl     = regWrEn && (regAddr == `AM_OFS_DEV_CTRL);
  assign wrEvtCount = regWrEn && (regAddr == `AM_OFS_EVT_COUNT);

  // ****************************************************************
  // Power state and comparator enable
  // ****************************************************************
  logic pdGlobalNow;
  logic pdExit;

  // Either the pin or the register bit holds the part in global power-down
  assign pdGlobalNow = regs_ff.ctrl[`AM_CTRL_PD_GLOBAL] | powerdownPin;
  assign pdExit      = regs_ff.pdPrev & ~pdGlobalNow;

  // Comparison only means something with the output path on and both
  // channels running; the host sequence relies on that gating
  assign cmpLink.enable   = regs_ff.ctrl[`AM_CTRL_OUT_EN]
                          & ~regs_ff.ctrl[`AM_CTRL_PD_A]
                          & ~regs_ff.ctrl[`AM_CTRL_PD_B]
                          & ~pdGlobalNow;
  assign cmpLink.chanAClk = chanAClocks;
  assign cmpLink.chanBClk = chanBClocks;

  clock_compare cmpUnit (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .cmp      (cmpLink.comparator)
  );

  // ****************************************************************
  // Alarm events
  // ****************************************************************
  logic [`AM_NUM_ALARMS-1:0] alarmEvt;

  assign alarmEvt[`AM_BIT_REALIGN]   = sysrefRealign;
  // Waking from global power-down disturbs the clocks, so flag it
  assign alarmEvt[`AM_BIT_CLK_UPSET] = cmpLink.upsetPulse | pdExit;

  // ****************************************************************
  // Per-alarm sticky status and event counters
  // ****************************************************************
  logic [`AM_NUM_ALARMS-1:0] statusNext;
  logic [`AM_CNT_W-1:0]      cntNext [`AM_NUM_ALARMS];
  logic [`AM_CNT_W-1:0]      cntCur  [`AM_NUM_ALARMS];

  assign cntCur[`AM_BIT_REALIGN]   = regs_ff.cntRealign;
  assign cntCur[`AM_BIT_CLK_UPSET] = regs_ff.cntUpset;

  genvar gi;
  generate
    for (gi = 0; gi < `AM_NUM_ALARMS; gi++) begin : genAlarm
      logic clearBit;
      assign clearBit = wrStatus & regWrData[gi];
      // Own bit per source; a fresh event outranks a clear in the same cycle
      assign statusNext[gi] = alarmEvt[gi] | (regs_ff.status[gi] & ~clearBit);
      // Counters saturate so software never sees a wrap to zero
      always_comb begin
        if (wrEvtCount) begin
          cntNext[gi] = '0;
        end else if (alarmEvt[gi] && (cntCur[gi] != {`AM_CNT_W{1'b1}})) begin
          cntNext[gi] = cntCur[gi] + `AM_CNT_W'(1);
        end else begin
          cntNext[gi] = cntCur[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [`AM_DATA_W-1:0] rdMux;

  always_comb begin
    rdMux = '0;
    unique case (regAddr)
      `AM_OFS_SUMMARY: begin
        rdMux[0] = regs_ff.irq;
      end
      `AM_OFS_STATUS: begin
        rdMux[`AM_NUM_ALARMS-1:0] = regs_ff.status;
      end
      `AM_OFS_MASK: begin
        rdMux[`AM_NUM_ALARMS-1:0] = regs_ff.mask;
      end
      `AM_OFS_PIN_CFG: begin
        rdMux[`AM_PIN_SEL_W-1:0] = regs_ff.pinSel;
      end
      `AM_OFS_DEV_CTRL: begin
        rdMux[3:0] = regs_ff.ctrl;
      end
      `AM_OFS_EVT_COUNT: begin
        rdMux[2*`AM_CNT_W-1:0] = {regs_ff.cntUpset, regs_ff.cntRealign};
      end
      `AM_OFS_MON_STATE: begin
        rdMux[1:0] = cmpLink.state;
        rdMux[4]   = cmpLink.enable;
        rdMux[5]   = pdGlobalNow;
      end
      `AM_OFS_FIRST_ALARM: begin
        rdMux[`AM_NUM_ALARMS-1:0] = regs_ff.first;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [`AM_NUM_ALARMS-1:0] unmaskedNext;

  always_comb begin
    nxt_regs            = regs_ff;
    nxt_regs.status     = statusNext;
    nxt_regs.cntRealign = cntNext[`AM_BIT_REALIGN];
    nxt_regs.cntUpset   = cntNext[`AM_BIT_CLK_UPSET];
    nxt_regs.pdPrev     = pdGlobalNow;
    nxt_regs.rdData     = regRdEn ? rdMux : '0;

    if (wrMask) begin
      nxt_regs.mask = regWrData[`AM_NUM_ALARMS-1:0];
    end
    if (wrPinCfg) begin
      nxt_regs.pinSel = regWrData[`AM_PIN_SEL_W-1:0];
    end
    if (wrCtrl) begin
      nxt_regs.ctrl = regWrData[3:0];
    end

    // Record which source fired first out of an all-clear status
    if (regs_ff.status == '0 && statusNext != '0) begin
      nxt_regs.first = alarmEvt;
    end else if (statusNext == '0) begin
      nxt_regs.first = '0;
    end

    // Masked types stay in status but never reach the summary
    unmaskedNext = nxt_regs.status & ~nxt_regs.mask;
    nxt_regs.irq = |unmaskedNext;

    // Pin follows the summary only when the alarm source is chosen
    if (nxt_regs.pinSel == `AM_PIN_SEL_ALARM) begin
      nxt_regs.statusPin = |unmaskedNext;
    end else if (nxt_regs.pinSel == `AM_PIN_SEL_CAL) begin
      nxt_regs.statusPin = calDoneIn;
    end else begin
      nxt_regs.statusPin = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regs_ff <= '{mask: `AM_MASK_RST, pinSel: `AM_PIN_SEL_RST, ctrl: `AM_CTRL_RST,
                   default: '0};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign regRdData    = regs_ff.rdData;
  assign alarmIrq     = regs_ff.irq;
  assign statusOutPin = regs_ff.statusPin;

endmodule // alarm_monitor

// file: verif/alarm_monitor_monitor.sv
`timescale 1ns/1ns
`include "alarm_monitor_defines.svh"

module alarm_monitor_monitor (
  input wire logic                  core_clk,      // Clock
  input wire logic                  sys_rst,       // Sync reset
  input wire logic [`AM_ADDR_W-1:0] regAddr,       // Address
  input wire logic [`AM_DATA_W-1:0] regWrData,     // Write data
  input wire logic                  regWrEn,       // Write strobe
  input wire logic                  regRdEn,       // Read strobe
  input wire logic [`AM_DATA_W-1:0] regRdData,     // Read data
  input wire logic                  sysrefRealign, // Realign event
  input wire logic [`AM_CLK_W-1:0]  chanAClocks,   // Channel A clocks
  input wire logic [`AM_CLK_W-1:0]  chanBClocks,   // Channel B clocks
  input wire logic                  powerdownPin,  // Power-down pin
  input wire logic                  calDoneIn,     // Calibration level
  input wire logic                  statusOutPin,  // Status pin
  input wire logic                  alarmIrq       // Summary alarm
);
  logic [1:0] maskMir_ff;
  logic [1:0] selMir_ff;
  logic [3:0] ctrlMir_ff;
  logic [3:0] runCnt_ff;
  logic [1:0] pdQuiet_ff;
  logic       wrMask;
  assign wrMask = regWrEn && regAddr == `AM_OFS_MASK;
  // ****************************************************************
  // Mirrors of setup, so expectations need no read-back
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      maskMir_ff <= 2'h0;
      selMir_ff  <= 2'h0;
      ctrlMir_ff <= 4'h0;
      runCnt_ff  <= 4'h0;
      pdQuiet_ff <= 2'h0;
    end else begin
      if (wrMask) maskMir_ff <= regWrData[1:0];
      if (regWrEn && regAddr == `AM_OFS_PIN_CFG) selMir_ff <= regWrData[1:0];
      if (regWrEn && regAddr == `AM_OFS_DEV_CTRL) ctrlMir_ff <= regWrData[3:0];
      // Long enough to cover the comparator settle time
      if (ctrlMir_ff != 4'h1 || powerdownPin) runCnt_ff <= 4'h0;
      else if (runCnt_ff != 4'hf) runCnt_ff <= runCnt_ff + 4'h1;
      if (powerdownPin || ctrlMir_ff[3]) pdQuiet_ff <= 2'h0;
      else if (pdQuiet_ff != 2'h3) pdQuiet_ff <= pdQuiet_ff + 2'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_realign_raises_irq: assert property (sysrefRealign && !maskMir_ff[0] && !wrMask
    |=> alarmIrq) else $error("realign did not raise irq");
  chk_irq_stays_set: assert property (alarmIrq && !regWrEn |=> alarmIrq)
    else $error("irq dropped without a write");
  chk_clear_drops_irq: assert property (regWrEn && regAddr == `AM_OFS_STATUS
    && regWrData[1:0] == 2'h3 && !sysrefRealign && ctrlMir_ff == 4'h0 && pdQuiet_ff == 2'h3
    |=> !alarmIrq) else $error("clear write left irq high");
  chk_mask_blocks_irq: assert property (maskMir_ff == 2'h3 && $past(maskMir_ff) == 2'h3
    |-> !alarmIrq) else $error("irq high while all masked");
  chk_pin_alarm_mode: assert property (selMir_ff == `AM_PIN_SEL_ALARM
    && $past(selMir_ff) == `AM_PIN_SEL_ALARM |-> statusOutPin == alarmIrq)
    else $error("status pin differs from summary");
  chk_pin_cal_mode: assert property (selMir_ff == `AM_PIN_SEL_CAL && !$past(sys_rst)
    && $past(selMir_ff) == `AM_PIN_SEL_CAL |-> statusOutPin == $past(calDoneIn))
    else $error("status pin not following calibration level");
  chk_pin_off_mode: assert property (selMir_ff[1] && $past(selMir_ff[1]) |-> !statusOutPin)
    else $error("status pin high in unused mode");
  chk_read_one_cycle: assert property (regRdData != 32'h0 |-> $past(regRdEn))
    else $error("read data outside its cycle");
  chk_pd_exit_upset: assert property ($fell(powerdownPin) && !ctrlMir_ff[3]
    && !maskMir_ff[1] |-> ##[0:2] alarmIrq) else $error("no upset after power-down exit");
  chk_upset_detected: assert property ((runCnt_ff == 4'hf && !maskMir_ff[1]
    && chanAClocks != chanBClocks)[*2] |-> ##[0:3] alarmIrq) else $error("clock upset missed");
  cover property (sysrefRealign && alarmIrq);
  cover property ($fell(powerdownPin));
  cover property (runCnt_ff == 4'hf && chanAClocks != chanBClocks);
endmodule // alarm_monitor_monitor

bind alarm_monitor alarm_monitor_monitor alarm_monitor_monitor_i (.core_clk(core_clk),
  .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .sysrefRealign(sysrefRealign),
  .chanAClocks(chanAClocks), .chanBClocks(chanBClocks), .powerdownPin(powerdownPin),
  .calDoneIn(calDoneIn), .statusOutPin(statusOutPin), .alarmIrq(alarmIrq));

// file: verif/alarm_monitor_bench.sv
`timescale 1ns/1ns
`include "alarm_monitor_defines.svh"

module alarm_monitor_bench;
  logic        core_clk      = 1'h0;
  logic        sys_rst       = 1'h1;
  logic [7:0]  regAddr       = 8'h00;
  logic [31:0] regWrData     = 32'h0;
  logic        regWrEn       = 1'h0;
  logic        regRdEn       = 1'h0;
  logic [31:0] regRdData;
  logic        sysrefRealign = 1'h0;
  logic [3:0]  chanAClocks   = 4'h5;
  logic [3:0]  chanBClocks   = 4'h5;
  logic        powerdownPin  = 1'h0;
  logic        calDoneIn     = 1'h0;
  logic        statusOutPin;
  logic        alarmIrq;
  int          errCount      = 0;
  int          cmpCount      = 0;

  always #10 core_clk = ~core_clk;

  alarm_monitor alarm_monitor_i (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .sysrefRealign(sysrefRealign), .chanAClocks(chanAClocks), .chanBClocks(chanBClocks),
    .powerdownPin(powerdownPin), .calDoneIn(calDoneIn), .statusOutPin(statusOutPin),
    .alarmIrq(alarmIrq));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task giveVerdict;
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'h1;
    @(posedge core_clk);
    regWrEn   <= 1'h0;
    #1;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge core_clk);
    regRdEn <= 1'h0;
    #1;
    chk(nm, regRdData, exp);
  endtask
  task pulse;
    @(posedge core_clk);
    sysrefRealign <= 1'h1;
    @(posedge core_clk);
    sysrefRealign <= 1'h0;
    #1;
  endtask
  task waitIrq;
    int i;
    for (i = 0; i < 20 && alarmIrq !== 1'h1; i++) @(posedge core_clk);
    if (alarmIrq !== 1'h1) begin
      errCount++;
      $display("mismatch alarmIrq expected 1 seen timeout");
      giveVerdict;
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    rc(`AM_OFS_MASK, 32'h0, "mask reset");
    rc(`AM_OFS_PIN_CFG, 32'h0, "pin select reset");
    rc(`AM_OFS_STATUS, 32'h0, "status reset");
    wr(8'h20, 32'hffffffff);
    rc(8'h20, 32'h0, "unmapped read");
    chk("irq after reset", 32'(alarmIrq), 32'h0);
    $display("test reset done");
  endtask
  task t_realign;
    pulse;
    chk("irq on realign", 32'(alarmIrq), 32'h1);
    rc(`AM_OFS_STATUS, 32'h1, "realign bit");
    wr(`AM_OFS_STATUS, 32'h0);
    tick(3);
    rc(`AM_OFS_STATUS, 32'h1, "zero write keeps");
    @(posedge core_clk);
    regAddr       <= `AM_OFS_STATUS;
    regWrData     <= 32'h1;
    regWrEn       <= 1'h1;
    sysrefRealign <= 1'h1;
    @(posedge core_clk);
    regWrEn       <= 1'h0;
    sysrefRealign <= 1'h0;
    rc(`AM_OFS_STATUS, 32'h1, "event beats clear");
    wr(`AM_OFS_STATUS, 32'h3);
    chk("irq after clear", 32'(alarmIrq), 32'h0);
    rc(`AM_OFS_STATUS, 32'h0, "status after clear");
    $display("test realign done");
  endtask
  task t_mask;
    wr(`AM_OFS_MASK, 32'h3);
    pulse;
    chk("irq masked", 32'(alarmIrq), 32'h0);
    rc(`AM_OFS_SUMMARY, 32'h0, "summary masked");
    rc(`AM_OFS_STATUS, 32'h1, "status masked");
    wr(`AM_OFS_MASK, 32'h2);
    chk("irq unmasked", 32'(alarmIrq), 32'h1);
    rc(`AM_OFS_SUMMARY, 32'h1, "summary unmasked");
    wr(`AM_OFS_MASK, 32'h0);
    wr(`AM_OFS_STATUS, 32'h1);
    $display("test mask done");
  endtask
  task t_pin;
    @(posedge core_clk);
    calDoneIn <= 1'h1;
    tick(2);
    #1;
    chk("pin cal", 32'(statusOutPin), 32'h1);
    wr(`AM_OFS_PIN_CFG, 32'(`AM_PIN_SEL_ALARM));
    chk("pin idle", 32'(statusOutPin), 32'h0);
    pulse;
    chk("pin alarm", 32'(statusOutPin), 32'h1);
    wr(`AM_OFS_PIN_CFG, 32'h2);
    chk("pin off", 32'(statusOutPin), 32'h0);
    wr(`AM_OFS_STATUS, 32'h1);
    wr(`AM_OFS_PIN_CFG, 32'h0);
    @(posedge core_clk);
    calDoneIn <= 1'h0;
    $display("test pin done");
  endtask
  task t_upset;
    wr(`AM_OFS_DEV_CTRL, 32'h0);
    wr(`AM_OFS_DEV_CTRL, 32'h1);
    tick(16);
    wr(`AM_OFS_STATUS, 32'h2);
    tick(4);
    #1;
    chk("no upset on equal clocks", 32'(alarmIrq), 32'h0);
    rc(`AM_OFS_MON_STATE, 32'h12, "comparator running");
    @(posedge core_clk);
    chanBClocks <= 4'ha;
    tick(2);
    chanBClocks <= 4'h5;
    waitIrq;
    rc(`AM_OFS_STATUS, 32'h2, "upset bit");
    wr(`AM_OFS_STATUS, 32'h2);
    wr(`AM_OFS_DEV_CTRL, 32'h3);
    @(posedge core_clk);
    chanBClocks <= 4'ha;
    tick(8);
    chanBClocks <= 4'h5;
    #1;
    chk("comparator off", 32'(alarmIrq), 32'h0);
    rc(`AM_OFS_MON_STATE, 32'h0, "comparator state off");
    wr(`AM_OFS_DEV_CTRL, 32'h0);
    $display("test upset done");
  endtask
  task t_pdexit;
    @(posedge core_clk);
    powerdownPin <= 1'h1;
    tick(4);
    powerdownPin <= 1'h0;
    waitIrq;
    rc(`AM_OFS_FIRST_ALARM, 32'h2, "first alarm upset");
    rc(`AM_OFS_STATUS, 32'h2, "pin exit upset");
    wr(`AM_OFS_STATUS, 32'h2);
    wr(`AM_OFS_DEV_CTRL, 32'h8);
    wr(`AM_OFS_DEV_CTRL, 32'h0);
    waitIrq;
    rc(`AM_OFS_STATUS, 32'h2, "ctrl exit upset");
    wr(`AM_OFS_STATUS, 32'h2);
    chk("irq after exit clear", 32'(alarmIrq), 32'h0);
    rc(`AM_OFS_FIRST_ALARM, 32'h0, "first alarm cleared");
    rc(`AM_OFS_EVT_COUNT, 32'h0304, "event counts");
    wr(`AM_OFS_EVT_COUNT, 32'h0);
    rc(`AM_OFS_EVT_COUNT, 32'h0, "event counts cleared");
    $display("test power-down exit done");
  endtask

  initial begin
    tick(6);
    sys_rst <= 1'h0;
    t_reset;
    t_realign;
    t_mask;
    t_pin;
    t_upset;
    t_pdexit;
    giveVerdict;
  end
endmodule // alarm_monitor_bench
